// >>> rtl/sdrw_pkg.sv
package sdrw_pkg;
    // ------------------------------------------------------------
    // widths and depths
    // ------------------------------------------------------------
    localparam int RESULT_W = 16;
    localparam int FIFO_AW = 3;
    // ------------------------------------------------------------
    // reset values and pointer increment
    // ------------------------------------------------------------
    localparam logic [RESULT_W-1:0] RESULT_RST = 16'h0000;
    localparam logic [FIFO_AW:0] PTR_RST = 4'h0;
    localparam logic [FIFO_AW:0] PTR_ONE = 4'h1;
    // ------------------------------------------------------------
    // conversion sequencer states
    // ------------------------------------------------------------
    typedef enum logic [0:0] {
        SDRW_IDLE = 1'b0,
        SDRW_CONV = 1'b1
    } sdrw_conv_state_type;
endpackage

// >>> rtl/sdrw_mem_if.sv
`timescale 1ns/10ps
interface sdrw_mem_if #(
    parameter int DW = 16,
    parameter int AW = 3
);
    logic we;
    logic [AW-1:0] waddr;
    logic [DW-1:0] wdata;
    logic re;
    logic [AW-1:0] raddr;
    logic [DW-1:0] rdata;
    modport mem (input we, input waddr, input wdata, input re, input raddr, output rdata);
    modport user (output we, output waddr, output wdata, output re, output raddr, input rdata);
endinterface

// >>> rtl/sdrw_mem.sv
`timescale 1ns/10ps
module sdrw_mem #(
    parameter int DW = 16,
    parameter int AW = 3
) (
    input wire logic clk,
    input wire logic resetn,
    sdrw_mem_if.mem port
);
    logic [DW-1:0] store [0:(1<<AW)-1];
    logic [DW-1:0] rdata_r;

    always_ff @(posedge clk) begin
        if (port.we) begin
            store[port.waddr] <= port.wdata;
        end
    end

    // read data always comes out of a register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_r <= '0;
        end else if (port.re) begin
            rdata_r <= store[port.raddr];
        end
    end

    assign port.rdata = rdata_r;
endmodule

// >>> rtl/sdrw_top.sv
// How it works
// R01 - event when result above upper limit
// R02 - event when result below lower limit
// R03 - limit check enable off: no limit events
// R04 - enabled conversion: store result, push, irq/dma
// R05 - enable off: no results, pushes, irq, dma
// R06 - enable off: analog part powered down
// R07 - software triggers only after enabling
// R08 - software gates clock or selects external modulator; code has no clock gate, external_modulator_select halts the filter path
// R09 - limits and results compared as signed
`timescale 1ns/10ps
module sdrw_top #(
    parameter int RESULT_W = sdrw_pkg::RESULT_W,
    parameter int FIFO_AW = sdrw_pkg::FIFO_AW
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic module_enable,
    input wire logic limit_check_enable,
    input wire logic external_modulator_select,
    input wire logic irq_enable,
    input wire logic dma_enable,
    input wire logic [RESULT_W-1:0] upper_limit,
    input wire logic [RESULT_W-1:0] lower_limit,
    input wire logic conv_trigger,
    input wire logic sample_valid,
    input wire logic [RESULT_W-1:0] sample_data,
    input wire logic fifo_pop,
    input wire logic overflow_clear,
    output logic [RESULT_W-1:0] channel_result_register,
    output logic result_valid,
    output logic busy,
    output logic limit_high_evt,
    output logic limit_low_evt,
    output logic irq,
    output logic dma_req,
    output logic [RESULT_W-1:0] fifo_data,
    output logic fifo_data_valid,
    output logic fifo_empty,
    output logic fifo_full,
    output logic fifo_overflow,
    output logic analog_power_down
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        sdrw_pkg::sdrw_conv_state_type st;
        logic [RESULT_W-1:0] result;
        logic result_valid;
        logic hi;
        logic lo;
        logic irq;
        logic dma;
        logic rd_valid;
        logic empty;
        logic full;
        logic ovf;
        logic pd;
        logic [FIFO_AW:0] wr_ptr;
        logic [FIFO_AW:0] rd_ptr;
    } sdrw_state_type;

    sdrw_state_type s_r;
    sdrw_state_type s_nxt;
    logic accept;
    logic push;
    logic pop;
    logic digital_run;

    sdrw_mem_if #(.DW(RESULT_W), .AW(FIFO_AW)) mem_bus ();

    sdrw_mem #(.DW(RESULT_W), .AW(FIFO_AW)) u_mem (
        .clk(clk),
        .resetn(resetn),
        .port(mem_bus)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        // external modulator mode also halts the internal filter path
        digital_run = module_enable && !external_modulator_select; // R05
        accept = digital_run && (s_r.st == sdrw_pkg::SDRW_CONV) && sample_valid; // R04
        push = accept && !s_r.full;
        pop = fifo_pop && !s_r.empty;
        s_nxt.result_valid = 1'b0;
        s_nxt.hi = 1'b0;
        s_nxt.lo = 1'b0;
        s_nxt.irq = 1'b0;
        s_nxt.dma = 1'b0;
        s_nxt.rd_valid = pop;
        s_nxt.pd = !module_enable; // R06
        case (s_r.st)
            sdrw_pkg::SDRW_IDLE: begin
                // triggers before enabling are dropped
                if (digital_run && conv_trigger) begin // R07
                    s_nxt.st = sdrw_pkg::SDRW_CONV;
                end
            end
            sdrw_pkg::SDRW_CONV: begin
                if (!digital_run || accept) begin // R05
                    s_nxt.st = sdrw_pkg::SDRW_IDLE;
                end
            end
            default: begin
                s_nxt.st = sdrw_pkg::SDRW_IDLE;
            end
        endcase
        if (accept) begin // R04
            s_nxt.result = sample_data;
            s_nxt.result_valid = 1'b1;
            s_nxt.irq = irq_enable;
            s_nxt.dma = dma_enable;
            if (limit_check_enable) begin // R03
                s_nxt.hi = $signed(sample_data) > $signed(upper_limit); // R01 R09
                s_nxt.lo = $signed(sample_data) < $signed(lower_limit); // R02 R09
            end
        end
        if (push) begin
            s_nxt.wr_ptr = s_r.wr_ptr + sdrw_pkg::PTR_ONE;
        end
        if (pop) begin
            s_nxt.rd_ptr = s_r.rd_ptr + sdrw_pkg::PTR_ONE;
        end
        // overflow set wins over clear
        if (accept && s_r.full) begin
            s_nxt.ovf = 1'b1;
        end else if (overflow_clear) begin
            s_nxt.ovf = 1'b0;
        end
        s_nxt.empty = s_nxt.wr_ptr == s_nxt.rd_ptr;
        s_nxt.full = (s_nxt.wr_ptr[FIFO_AW-1:0] == s_nxt.rd_ptr[FIFO_AW-1:0])
            && (s_nxt.wr_ptr[FIFO_AW] != s_nxt.rd_ptr[FIFO_AW]);
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_r <= '{st: sdrw_pkg::SDRW_IDLE, result: sdrw_pkg::RESULT_RST,
                result_valid: 1'b0, hi: 1'b0, lo: 1'b0, irq: 1'b0, dma: 1'b0,
                rd_valid: 1'b0, empty: 1'b1, full: 1'b0, ovf: 1'b0, pd: 1'b1,
                wr_ptr: sdrw_pkg::PTR_RST, rd_ptr: sdrw_pkg::PTR_RST};
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // fifo storage and outputs
    // ------------------------------------------------------------
    assign mem_bus.we = push; // R04
    assign mem_bus.waddr = s_r.wr_ptr[FIFO_AW-1:0];
    assign mem_bus.wdata = sample_data;
    assign mem_bus.re = pop;
    assign mem_bus.raddr = s_r.rd_ptr[FIFO_AW-1:0];

    assign channel_result_register = s_r.result;
    assign result_valid = s_r.result_valid;
    assign busy = s_r.st == sdrw_pkg::SDRW_CONV;
    assign limit_high_evt = s_r.hi;
    assign limit_low_evt = s_r.lo;
    assign irq = s_r.irq;
    assign dma_req = s_r.dma;
    assign fifo_data = mem_bus.rdata;
    assign fifo_data_valid = s_r.rd_valid;
    assign fifo_empty = s_r.empty;
    assign fifo_full = s_r.full;
    assign fifo_overflow = s_r.ovf;
    assign analog_power_down = s_r.pd;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // range watchdog events
    AST_HIGH: assert property (@(posedge clk) disable iff (!resetn) // R01
        result_valid && $past(limit_check_enable)
        && ($signed(channel_result_register) > $signed($past(upper_limit)))
        |-> limit_high_evt) else $error("missing upper limit event");
    AST_HIGH_ONLY: assert property (@(posedge clk) disable iff (!resetn) // R01
        limit_high_evt |-> result_valid && $past(limit_check_enable)
        && ($signed(channel_result_register) > $signed($past(upper_limit))))
        else $error("upper limit event without high result");
    AST_LOW: assert property (@(posedge clk) disable iff (!resetn) // R02
        result_valid && $past(limit_check_enable)
        && ($signed(channel_result_register) < $signed($past(lower_limit)))
        |-> limit_low_evt) else $error("missing lower limit event");
    // low limit must not act as a second upper limit
    AST_LOW_ONLY: assert property (@(posedge clk) disable iff (!resetn) // R02
        limit_low_evt |-> result_valid && $past(limit_check_enable)
        && ($signed(channel_result_register) < $signed($past(lower_limit))))
        else $error("lower limit event without low result");
    AST_LIMIT_OFF: assert property (@(posedge clk) disable iff (!resetn) // R03

        !$past(limit_check_enable) |-> !limit_high_evt && !limit_low_evt)
        else $error("limit event while check disabled");

    // result path
    AST_STORE: assert property (@(posedge clk) disable iff (!resetn) // R04
        module_enable && !external_modulator_select && busy && sample_valid && !fifo_full
        |=> result_valid && channel_result_register == $past(sample_data)
        && $past(mem_bus.we) && !fifo_empty)
        else $error("result not stored");
    AST_FLAGS: assert property (@(posedge clk) disable iff (!resetn) // R04
        accept |=> irq == $past(irq_enable) && dma_req == $past(dma_enable))
        else $error("irq or dma not as configured");

    // disable and halt
    AST_STOP: assert property (@(posedge clk) disable iff (!resetn) // R05
        !module_enable |=> !result_valid && !irq && !dma_req && $stable(s_r.wr_ptr) && !busy)
        else $error("activity after disable");
    AST_NO_START: assert property (@(posedge clk) disable iff (!resetn) // R05
        !module_enable && !busy |=> !busy) else $error("conversion started while disabled");
    AST_EXT_HALT: assert property (@(posedge clk) disable iff (!resetn) // R05
        external_modulator_select |=> !result_valid && !busy && $stable(s_r.wr_ptr))
        else $error("activity with external modulator selected");
    AST_PD_ON: assert property (@(posedge clk) disable iff (!resetn) // R06
        $fell(module_enable) |=> analog_power_down [*1] ##0 !result_valid)
        else $error("analog part not powered down");
    AST_PD_OFF: assert property (@(posedge clk) disable iff (!resetn) // R06
        module_enable [*2] |-> !analog_power_down)
        else $error("analog part powered down while enabled");
    AST_SIGNED: assert property (@(posedge clk) disable iff (!resetn) // R09
        result_valid && channel_result_register[RESULT_W-1] && !$past(upper_limit[RESULT_W-1])
        |-> !limit_high_evt) else $error("unsigned upper compare");
    // overflow flag is sticky and its set beats a clear
    AST_OVF_SET: assert property (@(posedge clk) disable iff (!resetn)
        accept && fifo_full |=> fifo_overflow) else $error("overflow not flagged");
endmodule

// >>> dv/sdrw_mod_model.sv
`timescale 1ns/10ps
module sdrw_mod_model (
    input wire logic clk,
    input wire logic busy,
    input wire logic [sdrw_pkg::RESULT_W-1:0] data_in,
    output logic sample_valid,
    output logic [sdrw_pkg::RESULT_W-1:0] sample_data
);
    // one strobe per pending conversion
    initial begin
        sample_valid = 1'b0;
        forever begin
            @(posedge clk);
            #1;
            sample_valid = busy && !sample_valid;
        end
    end
    // released data line shows the inverse value
    assign sample_data = sample_valid ? data_in : ~data_in;
endmodule

// >>> dv/tb_sdrw_top.sv
`timescale 1ns/10ps
module tb_sdrw_top;
    localparam int W = sdrw_pkg::RESULT_W;
    localparam int DEPTH = 1 << sdrw_pkg::FIFO_AW;
    typedef struct packed {
        logic lim; logic ie; logic de; logic [W-1:0] up; logic [W-1:0] lo; logic [W-1:0] d;
        logic exp_hi; logic exp_lo;
    } sdrw_row_type;
    logic clk = 0, resetn = 0, men = 0, lim = 0, ems = 0, ie = 0, de = 0, trig = 0, pop = 0;
    logic ovc = 0;
    logic [W-1:0] up = 0, lo = 0, din = 0, sd, crr, fd;
    logic sv, busy, rv, hi, low, irq, dma, fdv, fe, apd, ff, ovf;
    int num_errors = 0, total_checks = 0;
    sdrw_row_type rows [6] = '{
        '{1'b1, 1'b1, 1'b1, 16'h0100, 16'hff00, 16'h0200, 1'b1, 1'b0},
        '{1'b1, 1'b0, 1'b1, 16'h0100, 16'hff00, 16'hfe00, 1'b0, 1'b1},
        '{1'b1, 1'b1, 1'b0, 16'h0100, 16'hff00, 16'h0050, 1'b0, 1'b0},
        '{1'b0, 1'b1, 1'b1, 16'h0100, 16'hff00, 16'h7fff, 1'b0, 1'b0},
        '{1'b1, 1'b0, 1'b0, 16'h0100, 16'h0100, 16'h0100, 1'b0, 1'b0},
        '{1'b1, 1'b1, 1'b1, 16'h7fff, 16'h8001, 16'h8000, 1'b0, 1'b1}};
    // ------------------------------------------------------------
    // design and modulator
    // ------------------------------------------------------------
    sdrw_top i_dut (.clk(clk), .resetn(resetn), .module_enable(men), .limit_check_enable(lim),
        .external_modulator_select(ems), .irq_enable(ie), .dma_enable(de), .upper_limit(up),
        .lower_limit(lo), .conv_trigger(trig), .sample_valid(sv), .sample_data(sd),
        .fifo_pop(pop), .overflow_clear(ovc), .channel_result_register(crr),
        .result_valid(rv), .busy(busy), .limit_high_evt(hi), .limit_low_evt(low), .irq(irq),
        .dma_req(dma), .fifo_data(fd), .fifo_data_valid(fdv), .fifo_empty(fe),
        .fifo_full(ff), .fifo_overflow(ovf), .analog_power_down(apd));
    sdrw_mod_model i_mod (.clk(clk), .busy(busy), .data_in(din), .sample_valid(sv),
        .sample_data(sd));
    always #50 clk = ~clk;
    // ------------------------------------------------------------
    // compare and sequence tasks
    // ------------------------------------------------------------
    task automatic chk1(input logic g, input logic e);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic chk16(input logic [W-1:0] g, input logic [W-1:0] e);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic run(input sdrw_row_type r);
        logic hit;
        lim = r.lim;
        ie = r.ie;
        de = r.de;
        up = r.up;
        lo = r.lo;
        din = r.d;
        trig = 1;
        @(posedge clk);
        #1 trig = 0;
        hit = 0;
        repeat (10) if (!hit) begin
            @(posedge clk);
            #1;
            hit = (rv === 1'b1);
        end
        chk1(hit, 1'b1);
        chk16(crr, r.d);
        chk1(hi, r.exp_hi);
        chk1(low, r.exp_lo);
        chk1(irq, r.ie);
        chk1(dma, r.de);
        pop = 1;
        @(posedge clk);
        #1 pop = 0;
        chk1(fdv, 1'b1);
        chk16(fd, r.d);
    endtask
    // trigger that must give nothing
    task automatic quiet();
        trig = 1;
        @(posedge clk);
        #1 trig = 0;
        repeat (6) begin
            @(posedge clk);
            #1;
            chk1(rv | irq | dma | hi | low | fdv, 1'b0);
        end
        chk1(fe, 1'b1);
    endtask
    // one conversion, no pop
    task automatic convert(input logic [W-1:0] d);
        din = d;
        trig = 1;
        @(posedge clk);
        #1 trig = 0;
        @(posedge clk);
        #1;
        chk1(rv, 1'b1);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clk);
        #1 resetn = 1;
        chk1(fe, 1'b1);
        chk1(apd, 1'b1);
        men = 1;
        @(posedge clk);
        #1;
        chk1(apd, 1'b0);
        $display("reset test done");
        foreach (rows[i]) run(rows[i]);
        $display("row tests done");
        for (int i = 0; i < DEPTH; i++) convert(16'h1000 + 16'(i));
        chk1(ff, 1'b1);
        convert(16'h00ff);
        chk1(ovf, 1'b1);
        chk1(ff, 1'b1);
        ovc = 1;
        @(posedge clk);
        #1 ovc = 0;
        chk1(ovf, 1'b0);
        pop = 1;
        for (int i = 0; i < DEPTH; i++) begin
            @(posedge clk);
            #1;
            chk1(fdv, 1'b1);
            chk16(fd, 16'h1000 + 16'(i));
        end
        pop = 0;
        chk1(fe, 1'b1);
        $display("fifo test done");
        trig = 1;
        @(posedge clk);
        #1 trig = 0;
        chk1(busy, 1'b1);
        men = 0;
        ems = 1;
        repeat (6) begin
            @(posedge clk);
            #1;
            chk1(rv | irq | dma | hi | low | fdv | busy, 1'b0);
        end
        chk1(fe, 1'b1);
        $display("abort test done");
        men = 0;
        ems = 0;
        din = 16'h0200;
        quiet();
        chk1(apd, 1'b1);
        $display("disable test done");
        men = 1;
        ems = 1;
        quiet();
        $display("external modulator test done");
        give_verdict();
    end
    initial begin
        #2000000;
        num_errors++;
        give_verdict();
    end
endmodule
